//--- uls_params.svh
// register offsets, field positions and reset values of the line-status block
`ifndef ULS_PARAMS_SVH
`define ULS_PARAMS_SVH
`define ULS_AW             4
`define ULS_RXBUF_OFS      4'h0
`define ULS_STAT_OFS       4'h5
`define ULS_TOGGLE_OFS     4'h5
`define ULS_ATC_OFS        4'hc
`define ULS_IEN_OFS        4'hd
`define ULS_STAT_FIFOERR   7
`define ULS_STAT_TEMT      6
`define ULS_STAT_THRE      5
`define ULS_STAT_BRK       4
`define ULS_STAT_FRM       3
`define ULS_STAT_PAR       2
`define ULS_STAT_OVR       1
`define ULS_STAT_DR        0
`define ULS_TGL_RXPOL      7
`define ULS_TGL_TXPOL      5
`define ULS_ATC_RXPOL      7
`define ULS_ATC_RXAUTO     6
`define ULS_ATC_TXPOL      5
`define ULS_ATC_TXAUTO     4
`define ULS_IEN_THRE       0
`define ULS_TGL_RST        8'h80
`define ULS_TGL_MASK       8'ha0
`define ULS_ATC_RST        8'h00
`define ULS_ATC_MASK       8'hf0
`define ULS_IEN_RST        8'h00
`define ULS_LC_PEN         3
`define ULS_LC_EVEN        4
`define ULS_LC_STICK       5
`endif

//--- uls_pkg.sv
// types shared by the line-status block
package uls_pkg;
    // one register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } uls_bus_t;
    // one character delivered by the receive shifter
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       stop_ok;
    } uls_rxchar_t;
    // one stored receive entry: data plus its line flags
    typedef struct packed {
        logic [7:0] data;
        logic       brk;
        logic       frm;
        logic       par;
    } uls_rxent_t;
endpackage

//--- uls_line_status.sv
// line status, receive buffer and transceiver toggle control of one channel
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "uls_params.svh"
module uls_line_status
    import uls_pkg::*;
#(
    parameter int DEPTH = 256,                  // receive fifo entries
    parameter int PW    = 8                     // pointer width
)(
    input  wire logic        sys_clk,           // 250 MHz clock
    input  wire logic        reset,             // synchronous, active high
    input  wire uls_bus_t    bus,               // register request
    output logic [7:0]       rdata,             // read data, cycle after rd
    input  wire logic        fifo_mode,         // 1: fifo, 0: one-byte buffer
    input  wire logic        nine_bit_mode,     // nine-bit multidrop mode
    input  wire logic [7:0]  line_control,      // parity field in [5:3]
    input  wire logic        rx_valid,          // one-cycle character strobe
    input  wire uls_rxchar_t rx_char,           // received character
    input  wire logic        tx_hold_empty,     // holding reg or tx fifo empty
    input  wire logic        tx_shift_empty,    // transmit shifter empty
    input  wire logic        rx_active,         // core wants receiver on
    input  wire logic        tx_active,         // core wants driver on
    output logic             tx_irq,            // holding-empty interrupt
    output logic             receive_enable_out,
    output logic             transmit_enable_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    uls_rxent_t      mem [DEPTH];               // receive storage
    logic [PW-1:0]   wp_ff, nxt_wp;             // write pointer
    logic [PW-1:0]   rp_ff, nxt_rp;             // read pointer
    logic [PW:0]     cnt_ff, nxt_cnt;           // stored characters
    logic [PW:0]     ecnt_ff, nxt_ecnt;         // stored errored characters
    logic            ovr_ff, nxt_ovr;           // overrun sticky
    logic            hack_ff, nxt_hack;         // head flags already reported
    logic [7:0]      tgl_ff, nxt_tgl;           // software toggle register
    logic [7:0]      atc_ff, nxt_atc;           // auto toggle register
    logic [7:0]      ien_ff, nxt_ien;           // interrupt enable register
    logic [7:0]      rdata_ff, nxt_rdata;       // read data
    logic            irq_ff, nxt_irq;           // interrupt output
    logic            rx_en_ff, nxt_rx_en;       // receive enable pin
    logic            tx_en_ff, nxt_tx_en;       // transmit enable pin
    logic [PW:0]     cap;                       // usable capacity
    logic            full;                      // storage full
    logic            push;                      // store a character
    logic            pop;                       // receive buffer read
    logic            exp_par;                   // expected parity bit
    uls_rxent_t      newent;                    // entry being stored
    uls_rxent_t      head;                      // entry at the head
    logic            new_err;                   // new entry carries an error
    logic [7:0]      stat_word;                 // assembled status
    logic            rxpol;                     // effective receive polarity
    logic            txpol;                     // effective transmit polarity

    // ****************************************************************
    // receive entry formation
    // ****************************************************************
    // parity check and flag forming for the incoming character
    always_comb
    begin
        cap  = fifo_mode ? (PW+1)'(DEPTH) : (PW+1)'(1);
        full = (cnt_ff >= cap);
        pop  = bus.rd && (bus.addr == `ULS_RXBUF_OFS) && (cnt_ff != '0);
        push = rx_valid && !full;
        // stick parity sends the inverse of the even select
        if (line_control[`ULS_LC_STICK])
            exp_par = ~line_control[`ULS_LC_EVEN];
        else
            exp_par = line_control[`ULS_LC_EVEN] ? ^rx_char.data : ~^rx_char.data;
        newent.data = rx_char.data;
        // a frame of zeros with no stop bit is a break
        newent.brk  = !rx_char.stop_ok && (rx_char.data == 8'h00)
                      && !rx_char.ninth;
        newent.frm  = !rx_char.stop_ok;
        if (nine_bit_mode)
            newent.par = rx_char.ninth;
        else
            newent.par = line_control[`ULS_LC_PEN]
                         && (rx_char.ninth != exp_par);
        new_err = newent.brk | newent.frm | newent.par;
        head    = mem[rp_ff];
    end

    // storage write, data only, no reset needed
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wp_ff] <= newent;
    end

    // ****************************************************************
    // pointers, counts and sticky flags
    // ****************************************************************
    // next pointer, count and flag values
    always_comb
    begin
        nxt_wp   = wp_ff;
        nxt_rp   = rp_ff;
        nxt_cnt  = cnt_ff;
        nxt_ecnt = ecnt_ff;
        nxt_ovr  = ovr_ff;
        nxt_hack = hack_ff;
        // one-byte mode keeps everything in slot zero
        if (push)
            nxt_wp = fifo_mode ? PW'(wp_ff + 1'b1) : '0;
        if (pop)
            nxt_rp = fifo_mode ? PW'(rp_ff + 1'b1) : '0;
        nxt_cnt = (PW+1)'(cnt_ff + push - pop);
        nxt_ecnt = (PW+1)'(ecnt_ff + (push && new_err)
                   - (pop && (head.brk | head.frm | head.par)));
        // overrun: sticky, clears on status read, set wins
        if (bus.rd && bus.addr == `ULS_STAT_OFS)
            nxt_ovr = 1'b0;
        if (rx_valid && full)
            nxt_ovr = 1'b1;
        // head flags hide after a status read until a new head
        if (bus.rd && bus.addr == `ULS_STAT_OFS)
            nxt_hack = 1'b1;
        if (pop || (cnt_ff == '0))
            nxt_hack = 1'b0;
    end

    // ****************************************************************
    // status assembly
    // ****************************************************************
    // line status as seen by a read this cycle
    always_comb
    begin
        stat_word = 8'h00;
        stat_word[`ULS_STAT_FIFOERR] = (ecnt_ff != '0);
        stat_word[`ULS_STAT_TEMT]    = tx_hold_empty && tx_shift_empty;
        stat_word[`ULS_STAT_THRE]    = tx_hold_empty;
        // error flags of the head, hidden once reported
        if (cnt_ff != '0 && !hack_ff)
        begin
            stat_word[`ULS_STAT_BRK] = head.brk;
            stat_word[`ULS_STAT_FRM] = head.frm;
            stat_word[`ULS_STAT_PAR] = head.par;
        end
        stat_word[`ULS_STAT_OVR] = ovr_ff;
        stat_word[`ULS_STAT_DR]  = (cnt_ff != '0);
    end

    // ****************************************************************
    // registers, read data and pins
    // ****************************************************************
    // register writes, read mux and pin levels
    always_comb
    begin
        nxt_tgl   = tgl_ff;
        nxt_atc   = atc_ff;
        nxt_ien   = ien_ff;
        nxt_rdata = 8'h00;
        // writes; unused toggle bits are masked off
        if (bus.wr)
        begin
            case (bus.addr)
                `ULS_TOGGLE_OFS: nxt_tgl = bus.wdata & `ULS_TGL_MASK;
                `ULS_ATC_OFS:    nxt_atc = bus.wdata & `ULS_ATC_MASK;
                `ULS_IEN_OFS:    nxt_ien = {7'h00, bus.wdata[`ULS_IEN_THRE]};
                default:         nxt_tgl = tgl_ff;
            endcase
        end
        // reads; unmapped addresses answer zero
        if (bus.rd)
        begin
            case (bus.addr)
                `ULS_RXBUF_OFS: nxt_rdata = head.data;
                `ULS_STAT_OFS:  nxt_rdata = stat_word;
                `ULS_ATC_OFS:   nxt_rdata = atc_ff;
                `ULS_IEN_OFS:   nxt_rdata = ien_ff;
                default:        nxt_rdata = 8'h00;
            endcase
        end
        // auto toggle control wins over the software polarity
        rxpol = atc_ff[`ULS_ATC_RXAUTO] ? atc_ff[`ULS_ATC_RXPOL]
                                       : tgl_ff[`ULS_TGL_RXPOL];
        txpol = atc_ff[`ULS_ATC_TXAUTO] ? atc_ff[`ULS_ATC_TXPOL]
                                       : tgl_ff[`ULS_TGL_TXPOL];
        nxt_rx_en = rxpol ? rx_active : ~rx_active;
        nxt_tx_en = txpol ? tx_active : ~tx_active;
        nxt_irq  = tx_hold_empty && ien_ff[`ULS_IEN_THRE];
    end

    // ****************************************************************
    // state registers
    // ****************************************************************
    // single registering process for all state except the receive storage
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wp_ff    <= '0;
            rp_ff    <= '0;
            cnt_ff   <= '0;
            ecnt_ff  <= '0;
            ovr_ff   <= 1'b0;
            hack_ff  <= 1'b0;
            tgl_ff   <= `ULS_TGL_RST;
            atc_ff   <= `ULS_ATC_RST;
            ien_ff   <= `ULS_IEN_RST;
            rdata_ff <= 8'h00;
            irq_ff   <= 1'b0;
            rx_en_ff <= 1'b0;
            tx_en_ff <= 1'b1;
        end
        else
        begin
            wp_ff    <= nxt_wp;
            rp_ff    <= nxt_rp;
            cnt_ff   <= nxt_cnt;
            ecnt_ff  <= nxt_ecnt;
            ovr_ff   <= nxt_ovr;
            hack_ff  <= nxt_hack;
            tgl_ff   <= nxt_tgl;
            atc_ff   <= nxt_atc;
            ien_ff   <= nxt_ien;
            rdata_ff <= nxt_rdata;
            irq_ff   <= nxt_irq;
            rx_en_ff <= nxt_rx_en;
            tx_en_ff <= nxt_tx_en;
        end
    end

    // outputs straight from flops
    assign rdata               = rdata_ff;
    assign tx_irq              = irq_ff;
    assign receive_enable_out  = rx_en_ff;
    assign transmit_enable_out = tx_en_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // temt read value ties to both empties
    temt_read_a: assert property (bus.rd && bus.addr == `ULS_STAT_OFS |=>
        rdata[`ULS_STAT_TEMT] == $past(tx_hold_empty && tx_shift_empty))
        else $error("temt status wrong");
    // thre read value follows holding empty
    thre_read_a: assert property (bus.rd && bus.addr == `ULS_STAT_OFS |=>
        rdata[`ULS_STAT_THRE] == $past(tx_hold_empty))
        else $error("thre status wrong");
    // interrupt one cycle after enabled empty
    irq_follow_a: assert property (tx_hold_empty && ien_ff[0] |=> tx_irq)
        else $error("interrupt missing");
    // full buffer character sets overrun, count unchanged
    overrun_set_a: assert property (rx_valid && full && !pop |=>
        ovr_ff && $stable(cnt_ff))
        else $error("overrun not handled");
    // a dropped character never moves the write pointer
    ovr_keep_a: assert property (rx_valid && full |=> $stable(wp_ff))
        else $error("stored data disturbed");
    // overrun flag drops after a status read unless set again
    ovr_clear_a: assert property (bus.rd && bus.addr == `ULS_STAT_OFS
        && !(rx_valid && full) |=> !ovr_ff)
        else $error("overrun not cleared");
    // status read never pops a character
    stat_nopop_a: assert property (bus.rd && bus.addr == `ULS_STAT_OFS
        && !rx_valid |=> cnt_ff == $past(cnt_ff))
        else $error("status read changed count");
    // receive buffer read removes exactly one character
    pop_count_a: assert property (pop && !rx_valid |=> cnt_ff == $past(cnt_ff) - 1'b1)
        else $error("pop count wrong");
    // data ready matches stored count
    ready_bit_a: assert property (bus.rd && bus.addr == `ULS_STAT_OFS |=>
        rdata[`ULS_STAT_DR] == ($past(cnt_ff) != '0))
        else $error("data ready wrong");
    // flag checks feed an empty buffer, so the new character is the head
    frame_flag_a: assert property (rx_valid && cnt_ff == '0 |=>
        head.frm == !$past(rx_char.stop_ok))
        else $error("framing flag wrong");
    // an all-zero frame without stop bit marks a break
    break_flag_a: assert property (rx_valid && cnt_ff == '0
        && !rx_char.stop_ok && rx_char.data == 8'h00 && !rx_char.ninth |=> head.brk)
        else $error("break flag missing");
    // nine-bit mode reports the ninth bit as address flag
    nine_flag_a: assert property (rx_valid && cnt_ff == '0 && nine_bit_mode
        |=> head.par == $past(rx_char.ninth))
        else $error("address flag wrong");
    // no parity check, no parity flag
    par_off_a: assert property (rx_valid && cnt_ff == '0 && !nine_bit_mode
        && !line_control[`ULS_LC_PEN] |=> !head.par)
        else $error("parity flag without check");
    // pins lag one clock, so polarity checks use last cycle's inputs
    rx_soft_a: assert property (!atc_ff[`ULS_ATC_RXAUTO] |=>
        receive_enable_out == ($past(tgl_ff[`ULS_TGL_RXPOL]) ? $past(rx_active)
                                                            : !$past(rx_active)))
        else $error("software receive polarity wrong");
    // auto receive polarity overrides software bit
    rx_auto_a: assert property (atc_ff[`ULS_ATC_RXAUTO] |=>
        receive_enable_out == ($past(atc_ff[`ULS_ATC_RXPOL]) ? $past(rx_active)
                                                            : !$past(rx_active)))
        else $error("receive polarity wrong");
    // software transmit polarity without auto toggle
    tx_soft_a: assert property (!atc_ff[`ULS_ATC_TXAUTO] |=>
        transmit_enable_out == ($past(tgl_ff[`ULS_TGL_TXPOL]) ? $past(tx_active)
                                                             : !$past(tx_active)))
        else $error("software transmit polarity wrong");
    // auto transmit polarity overrides software bit
    tx_auto_a: assert property (atc_ff[`ULS_ATC_TXAUTO] |=>
        transmit_enable_out == ($past(atc_ff[`ULS_ATC_TXPOL]) ? $past(tx_active)
                                                             : !$past(tx_active)))
        else $error("transmit polarity wrong");
    // unused toggle bits stay zero
    tgl_unused_a: assert property ((tgl_ff & 8'h5f) == 8'h00)
        else $error("unused toggle bits set");
    // errored entries never exceed stored ones
    err_count_a: assert property (ecnt_ff <= cnt_ff)
        else $error("error count too high");

    full_c:    cover property (rx_valid && full);
    break_c:   cover property (push && newent.brk);
    nine_c:    cover property (push && nine_bit_mode && newent.par);
    irq_c:     cover property ($rose(tx_irq));
    ovr_clr_c: cover property (ovr_ff && bus.rd && bus.addr == `ULS_STAT_OFS);

endmodule
`default_nettype wire

//--- uls_line_partner.sv
// serial-side model: receive shifter characters and transmitter state
`timescale 1ns/1ps
`default_nettype none
module uls_line_partner
    import uls_pkg::*;
(
    input  wire logic   sys_clk,          // block clock
    output logic        rx_valid,         // one-cycle character strobe
    output uls_rxchar_t rx_char,          // character beside the strobe
    output logic        tx_hold_empty,    // holding reg or tx fifo empty
    output logic        tx_shift_empty    // transmit shifter empty
);
    // idle line, empty transmitter
    initial
    begin
        rx_valid       = 1'b0;
        rx_char        = '0;
        tx_hold_empty  = 1'b1;
        tx_shift_empty = 1'b1;
    end
    // one frame; afterwards the char lines no longer show the last value
    task automatic send(input logic [7:0] d, input logic n, input logic s);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_char  <= '{data: d, ninth: n, stop_ok: s};
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_char  <= ~rx_char;
    endtask
    // transmitter occupancy as the core would show it
    task automatic set_tx(input logic h, input logic s);
        @(posedge sys_clk);
        tx_hold_empty  <= h;
        tx_shift_empty <= s;
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench of the line-status and toggle block
`timescale 1ns/1ps
`default_nettype none
`include "uls_params.svh"
module testbench;
    import uls_pkg::*;
    `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
    logic        sys_clk, reset, fifo_mode, nine_bit_mode, rx_valid;
    logic        tx_hold_empty, tx_shift_empty, rx_active, tx_active, tx_irq;
    logic        receive_enable_out, transmit_enable_out;
    logic [7:0]  rdata, line_control, v;
    uls_bus_t    bus;
    uls_rxchar_t rx_char;
    int          err_count, num_checks;
    logic [35:0] tbl [8];                 // mode, control, data, ninth, stop, status
    always #2 sys_clk = ~sys_clk;         // 250 MHz
    uls_line_status #(.DEPTH(4), .PW(2)) uls_line_status_i (
        .sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata),
        .fifo_mode(fifo_mode), .nine_bit_mode(nine_bit_mode),
        .line_control(line_control), .rx_valid(rx_valid), .rx_char(rx_char),
        .tx_hold_empty(tx_hold_empty), .tx_shift_empty(tx_shift_empty),
        .rx_active(rx_active), .tx_active(tx_active), .tx_irq(tx_irq),
        .receive_enable_out(receive_enable_out), .transmit_enable_out(transmit_enable_out));
    uls_line_partner uls_line_partner_i (
        .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_char(rx_char),
        .tx_hold_empty(tx_hold_empty), .tx_shift_empty(tx_shift_empty));
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
        `CHK(v, e)
    endtask
    // let registered outputs follow their inputs
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        sys_clk = 1'b0; reset = 1'b1; bus = '0; fifo_mode = 1'b1; nine_bit_mode = 1'b0;
        line_control = 8'h00; rx_active = 1'b1; tx_active = 1'b1;
        err_count = 0; num_checks = 0;
        tbl = '{36'h0_18_55_0_1_61, 36'h0_18_55_1_1_e5, 36'h0_18_41_0_0_e9,
                36'h0_00_00_0_0_f9, 36'h1_00_12_1_1_e5, 36'h1_00_12_0_1_61,
                36'h0_38_55_1_1_e5, 36'h0_08_55_1_1_61};
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        // ****************************************
        // transmitter status and interrupt
        // ****************************************
        settle();
        `CHK(tx_irq, 1'b0)
        `CHK(receive_enable_out, 1'b1)
        `CHK(transmit_enable_out, 1'b0)
        chk_rd(`ULS_STAT_OFS, 8'h60);
        wr(`ULS_IEN_OFS, 8'h01);
        settle();
        `CHK(tx_irq, 1'b1)
        uls_line_partner_i.set_tx(1'b1, 1'b0);
        chk_rd(`ULS_STAT_OFS, 8'h20);
        uls_line_partner_i.set_tx(1'b0, 1'b1);
        settle();
        `CHK(tx_irq, 1'b0)
        chk_rd(`ULS_STAT_OFS, 8'h00);
        uls_line_partner_i.set_tx(1'b1, 1'b1);
        $display("test transmit status done");
        // ****************************************
        // transceiver polarity and auto toggle
        // ****************************************
        wr(`ULS_TOGGLE_OFS, 8'h5f);
        settle();
        `CHK(receive_enable_out, 1'b0)
        `CHK(transmit_enable_out, 1'b0)
        wr(`ULS_TOGGLE_OFS, 8'ha0);
        rx_active <= 1'b0;
        tx_active <= 1'b0;
        settle();
        `CHK({receive_enable_out, transmit_enable_out}, 2'b00)
        wr(`ULS_ATC_OFS, 8'hff);
        chk_rd(`ULS_ATC_OFS, 8'hf0);
        wr(`ULS_ATC_OFS, 8'h50);
        settle();
        `CHK({receive_enable_out, transmit_enable_out}, 2'b11)
        wr(`ULS_ATC_OFS, 8'h40);
        settle();
        `CHK({receive_enable_out, transmit_enable_out}, 2'b10)
        wr(`ULS_ATC_OFS, 8'h00);
        chk_rd(4'h3, 8'h00);
        $display("test toggle done");
        // ****************************************
        // receive flags, head entry and pop
        // ****************************************
        for (int i = 0; i < 8; i++)
        begin
            nine_bit_mode <= tbl[i][32];
            line_control  <= tbl[i][31:24];
            uls_line_partner_i.send(tbl[i][23:16], tbl[i][12], tbl[i][8]);
            chk_rd(`ULS_STAT_OFS, tbl[i][7:0]);
            chk_rd(`ULS_STAT_OFS, tbl[i][7:0] & 8'he3);
            chk_rd(`ULS_RXBUF_OFS, tbl[i][23:16]);
            chk_rd(`ULS_STAT_OFS, 8'h60);
        end
        $display("test receive flags done");
        // ****************************************
        // overrun in fifo and single buffer
        // ****************************************
        nine_bit_mode <= 1'b0;
        line_control  <= 8'h00;
        for (int i = 0; i < 5; i++)
            uls_line_partner_i.send(8'h30 + i[7:0], 1'b0, 1'b1);
        chk_rd(`ULS_STAT_OFS, 8'h63);
        chk_rd(`ULS_STAT_OFS, 8'h61);
        for (int i = 0; i < 4; i++)
            chk_rd(`ULS_RXBUF_OFS, 8'h30 + i[7:0]);
        chk_rd(`ULS_STAT_OFS, 8'h60);
        fifo_mode <= 1'b0;
        uls_line_partner_i.send(8'ha0, 1'b0, 1'b1);
        uls_line_partner_i.send(8'ha1, 1'b0, 1'b1);
        chk_rd(`ULS_STAT_OFS, 8'h63);
        chk_rd(`ULS_RXBUF_OFS, 8'ha0);
        chk_rd(`ULS_STAT_OFS, 8'h60);
        $display("test overrun done");
        print_verdict();
    end
    `undef CHK
endmodule
`default_nettype wire
